//--- pkg/swire_pkg.sv
/*
 Constants, states and carrier types for the single-wire slave ROM command layer.
 Assumes a 50 MHz clock and a bus line already sampled synchronous to that clock.
*/
// What this block does
// RULE1: Master keeps the line high when pausing; long lows may reset slaves.
// RULE2: Access order: reset, one ROM command, function command, then data.
// RULE3: Master reset pulse is answered by a slave presence pulse.
// RULE4: After presence the master sends an 8-bit ROM command for decoding.
// RULE5: Read identity 33h sends family code, 48-bit serial and CRC.
// RULE6: Master uses read identity only with a single slave attached.
// RULE7: Match 55h takes 64 identity bits; only an exact match proceeds.
// RULE8: A non-matching slave ignores traffic until the next reset.
// RULE9: Search F0h: slave sends bit, then complement, then master writes bit.
// RULE10: Master repeats the three-slot step for all 64 identity bits.
// RULE11: Skip CCh passes straight to function commands without identity bits.
// RULE12: Overdrive skip 3Ch acts as skip and sets the overdrive flag.
// RULE13: A reset pulse of at least 480 us clears the overdrive flag.
// RULE14: After overdrive skip the master selects with overdrive reset and match.
// RULE15: The line is driven only open-drain, combining as wired-AND.
// RULE16: Regular speed up to 16.3 kbit/s, overdrive up to 142 kbit/s.
// RULE17: The slave syncs every time slot to the master's falling edge.
// RULE18: Overdrive match 69h matches at overdrive speed and enters overdrive.
// RULE19: Resume A5h acts as skip only while the resume flag is set.
// RULE20: Resume flag set by successful selection, cleared when another is addressed.
// RULE21: In overdrive, a reset of at most 80 us keeps overdrive.
// RULE22: In search, a slave whose bit differs from the master's drops out.
// RULE23: Bits go least significant first; family code first, CRC last.
package swire_pkg;

   localparam int unsigned CLK_MHZ       = 50;
   // Regular speed timing and overdrive reset limits in us
   localparam int unsigned RST_MIN_US    = 480;
   localparam int unsigned OD_RST_MAX_US = 80;
   localparam int unsigned OD_RST_MIN_US = 48;
   localparam int unsigned RST_DET_US    = 240;
   localparam int unsigned PD_WAIT_US    = 30;
   localparam int unsigned PD_LOW_US     = 120;
   localparam int unsigned SAMPLE_US     = 30;
   localparam int unsigned DRIVE0_US     = 30;
   // Overdrive timing in us
   localparam int unsigned OD_RST_DET_US = 40;
   localparam int unsigned OD_PD_WAIT_US = 3;
   localparam int unsigned OD_PD_LOW_US  = 16;
   localparam int unsigned OD_SAMPLE_US  = 3;
   localparam int unsigned OD_DRIVE0_US  = 3;

   localparam int unsigned CW = 16;
   localparam logic [CW-1:0] RST_MIN_CYC     = CW'(RST_MIN_US * CLK_MHZ);
   localparam logic [CW-1:0] OD_RST_MAX_CYC  = CW'(OD_RST_MAX_US * CLK_MHZ);
   localparam logic [CW-1:0] RST_DET_CYC     = CW'(RST_DET_US * CLK_MHZ);
   localparam logic [CW-1:0] OD_RST_DET_CYC  = CW'(OD_RST_DET_US * CLK_MHZ);
   localparam logic [CW-1:0] PD_WAIT_CYC     = CW'(PD_WAIT_US * CLK_MHZ);
   localparam logic [CW-1:0] OD_PD_WAIT_CYC  = CW'(OD_PD_WAIT_US * CLK_MHZ);
   localparam logic [CW-1:0] PD_LOW_CYC      = CW'(PD_LOW_US * CLK_MHZ);
   localparam logic [CW-1:0] OD_PD_LOW_CYC   = CW'(OD_PD_LOW_US * CLK_MHZ);
   localparam logic [CW-1:0] SAMPLE_CYC      = CW'(SAMPLE_US * CLK_MHZ);
   localparam logic [CW-1:0] OD_SAMPLE_CYC   = CW'(OD_SAMPLE_US * CLK_MHZ);
   localparam logic [CW-1:0] DRIVE0_CYC      = CW'(DRIVE0_US * CLK_MHZ);
   localparam logic [CW-1:0] OD_DRIVE0_CYC   = CW'(OD_DRIVE0_US * CLK_MHZ);
   localparam logic [CW-1:0] CNT_MAX         = 16'hFFFF;

   localparam logic [7:0] CMD_READ_ID   = 8'h33;
   localparam logic [7:0] CMD_MATCH     = 8'h55;
   localparam logic [7:0] CMD_SEARCH    = 8'hF0;
   localparam logic [7:0] CMD_SKIP      = 8'hCC;
   localparam logic [7:0] CMD_OD_SKIP   = 8'h3C;
   localparam logic [7:0] CMD_OD_MATCH  = 8'h69;
   localparam logic [7:0] CMD_RESUME    = 8'hA5;

   localparam int unsigned ID_BITS  = 64;
   localparam int unsigned CMD_BITS = 8;
   localparam logic [6:0] ID_LAST   = 7'h3F;
   localparam logic [6:0] CMD_LAST  = 7'h07;
   localparam logic [6:0] IDX_ZERO  = 7'h00;
   localparam logic [1:0] PH_TRUE   = 2'h0;
   localparam logic [1:0] PH_CMPL   = 2'h1;
   localparam logic [1:0] PH_WRITE  = 2'h2;

   typedef enum logic [8:0] {
      ST_IDLE    = 9'h001,
      ST_PD_WAIT = 9'h002,
      ST_PD_LOW  = 9'h004,
      ST_CMD     = 9'h008,
      ST_SEND_ID = 9'h010,
      ST_MATCH   = 9'h020,
      ST_SEARCH  = 9'h040,
      ST_FUNC    = 9'h080,
      ST_WAIT    = 9'h100
   } rom_state_t;

   typedef struct packed {
      logic       od;
      logic       resume;
   } flags_t;

   typedef struct packed {
      logic       valid;
      logic       od;
   } select_t;

endpackage : swire_pkg

//--- hdl/swire_rom_layer.sv
/*
 Slave ROM command layer of a single-wire open-drain bus: reset detect, presence,
 ROM command decode, identity send, match, search, skip, overdrive and resume.
 Assumes line_in is the wired-AND bus level sampled on clk; the caller resolves
 the wire from line_oe (pull low when high). Function commands are handed on via sel.
*/
`timescale 1ns/1ns
module swire_rom_layer
   import swire_pkg::*;
#(
   parameter logic [ID_BITS-1:0] DEVICE_ID = 64'h0123_4567_89AB_CD00 // Arbitrary value
)(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       line_in,
   output logic            line_out,
   output logic            line_oe,
   output select_t         sel,
   output logic            reset_seen,
   output flags_t          flags
);

   // ****************************************
   // Slot timing
   // ****************************************
   rom_state_t     state_q, state_d;
   logic           line_q;
   logic [CW-1:0]  low_cnt_q;
   logic [CW-1:0]  slot_cnt_q;
   logic           in_slot_q;
   logic [6:0]     idx_q;
   logic [1:0]     phase_q;
   logic [7:0]     cmd_q;
   logic           miss_q;
   logic           oe_q;
   select_t        sel_q;
   flags_t         flags_q;
   logic           rst_pulse_q;

   wire fall        = line_q & ~line_in;
   wire rise        = ~line_q & line_in;
   wire [CW-1:0] rst_det   = flags_q.od ? OD_RST_DET_CYC : RST_DET_CYC;
   wire [CW-1:0] pd_wait   = flags_q.od ? OD_PD_WAIT_CYC : PD_WAIT_CYC;
   wire [CW-1:0] pd_low    = flags_q.od ? OD_PD_LOW_CYC : PD_LOW_CYC;
   wire [CW-1:0] smp_at    = flags_q.od ? OD_SAMPLE_CYC : SAMPLE_CYC;    // [RULE16]
   wire [CW-1:0] drv_len   = flags_q.od ? OD_DRIVE0_CYC : DRIVE0_CYC;
   wire bus_reset   = rise & (low_cnt_q >= rst_det);                    // [RULE3]
   wire long_reset  = rise & (low_cnt_q >= RST_MIN_CYC);                // [RULE13]
   wire sample      = in_slot_q & (slot_cnt_q == smp_at);               // [RULE17]
   wire id_bit      = DEVICE_ID[idx_q[5:0]];                            // [RULE23]
   wire tx_state    = (state_q == ST_SEND_ID) | ((state_q == ST_SEARCH) & (phase_q != PH_WRITE));
   wire tx_bit      = (state_q == ST_SEARCH && phase_q == PH_CMPL) ? ~id_bit : id_bit; // [RULE9]
   wire drive_zero  = tx_state & in_slot_q & ~tx_bit & (slot_cnt_q < drv_len);
   wire [7:0] cmd_full = {line_in, cmd_q[7:1]};                         // [RULE4]
   wire cmd_done    = sample & (state_q == ST_CMD) & (idx_q == CMD_LAST);
   wire id_done     = sample & (idx_q == ID_LAST);

   // ****************************************
   // Command sequencing
   // ****************************************
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE    : state_d = ST_IDLE;
         ST_PD_WAIT : if (slot_cnt_q >= pd_wait) state_d = ST_PD_LOW;
         ST_PD_LOW  : if (slot_cnt_q >= pd_low) state_d = ST_CMD;
         ST_CMD     : if (cmd_done) begin                               // [RULE2]
            unique case (cmd_full)
               CMD_READ_ID  : state_d = ST_SEND_ID;                     // [RULE5]
               CMD_MATCH,
               CMD_OD_MATCH : state_d = ST_MATCH;                       // [RULE7] [RULE18]
               CMD_SEARCH   : state_d = ST_SEARCH;                      // [RULE9]
               CMD_SKIP,
               CMD_OD_SKIP  : state_d = ST_FUNC;                        // [RULE11] [RULE12]
               CMD_RESUME   : state_d = flags_q.resume ? ST_FUNC : ST_WAIT; // [RULE19]
               default      : state_d = ST_WAIT;
            endcase
         end
         ST_SEND_ID : if (id_done) state_d = ST_WAIT;
         ST_MATCH   : if (id_done) state_d = (miss_q | (line_in != id_bit)) ? ST_WAIT : ST_FUNC; // [RULE8]
         ST_SEARCH  : if (sample && phase_q == PH_WRITE) begin
            if (line_in != id_bit) state_d = ST_WAIT;                   // [RULE22]
            else if (idx_q == ID_LAST) state_d = ST_FUNC;
         end
         ST_FUNC    : state_d = ST_FUNC;
         ST_WAIT    : state_d = ST_WAIT;
      endcase
      if (bus_reset) state_d = ST_PD_WAIT;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q    <= ST_IDLE;
         line_q     <= 1'b1;
         low_cnt_q  <= '0;
      end else begin
         state_q    <= state_d;
         line_q     <= line_in;
         low_cnt_q  <= line_in ? '0 : ((low_cnt_q == CNT_MAX) ? low_cnt_q : low_cnt_q + 1'b1);
      end
   end

   // Slot counter restarts on every master falling edge, or at presence phases
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_cnt_q <= '0;
         in_slot_q  <= 1'b0;
      end else if (bus_reset || state_d != state_q && (state_d == ST_PD_LOW)) begin
         slot_cnt_q <= '0;
         in_slot_q  <= 1'b0;
      end else if (fall && !oe_q) begin
         slot_cnt_q <= '0;
         in_slot_q  <= 1'b1;                                            // [RULE17]
      end else begin
         slot_cnt_q <= (slot_cnt_q == CNT_MAX) ? slot_cnt_q : slot_cnt_q + 1'b1;
         if (sample) in_slot_q <= 1'b0;
      end
   end

   // ****************************************
   // Bit counters and command shift
   // ****************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         idx_q   <= IDX_ZERO;
         phase_q <= PH_TRUE;
         cmd_q   <= '0;
         miss_q  <= 1'b0;
      end else if (bus_reset || cmd_done) begin
         idx_q   <= IDX_ZERO;
         phase_q <= PH_TRUE;
         miss_q  <= 1'b0;
      end else if (sample) begin
         if (state_q == ST_CMD) begin
            cmd_q <= cmd_full;
            idx_q <= idx_q + 1'b1;
         end else if (state_q == ST_SEARCH) begin
            phase_q <= (phase_q == PH_WRITE) ? PH_TRUE : phase_q + 1'b1;
            if (phase_q == PH_WRITE) idx_q <= idx_q + 1'b1;
         end else if (state_q == ST_MATCH) begin
            if (line_in != id_bit) miss_q <= 1'b1;                      // [RULE7]
            idx_q <= idx_q + 1'b1;
         end else if (state_q == ST_SEND_ID) begin
            idx_q <= idx_q + 1'b1;
         end
      end
   end

   // ****************************************
   // Flags and outputs
   // ****************************************
   wire is_od_cmd   = cmd_done & (cmd_full == CMD_OD_SKIP);
   wire is_odm_cmd  = cmd_done & (cmd_full == CMD_OD_MATCH);
   wire select_win  = (state_q != ST_FUNC) & (state_d == ST_FUNC) &
                      ((state_q == ST_MATCH) | (state_q == ST_SEARCH));
   wire select_lose = (state_q == ST_MATCH | state_q == ST_SEARCH) & (state_d == ST_WAIT);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_q     <= '0;
         sel_q       <= '0;
         oe_q        <= 1'b0;
         rst_pulse_q <= 1'b0;
      end else begin
         rst_pulse_q <= bus_reset;
         oe_q        <= (state_d == ST_PD_LOW) | drive_zero;            // [RULE15]
         if (long_reset) flags_q.od <= 1'b0;                            // [RULE13] [RULE21]
         else if (is_od_cmd || is_odm_cmd) flags_q.od <= 1'b1;          // [RULE12] [RULE18]
         if (select_win) flags_q.resume <= 1'b1;                        // [RULE20]
         else if (select_lose) flags_q.resume <= 1'b0;                  // [RULE20]
         sel_q.valid <= (state_d == ST_FUNC);
         sel_q.od    <= flags_q.od;
      end
   end

   assign line_out   = 1'b0;
   assign line_oe    = oe_q;
   assign sel        = sel_q;
   assign reset_seen = rst_pulse_q;
   assign flags      = flags_q;

endmodule // swire_rom_layer

//--- tb/swire_rom_sva.sv
/* Port checker for the ROM command layer.
   Assumes binding to swire_rom_layer, one clock, async rst. */
`timescale 1ns/1ns
module swire_rom_sva
   import swire_pkg::*;
(
   input wire logic    clk,
   input wire logic    rst,
   input wire logic    line_in,
   input wire logic    line_out,
   input wire logic    line_oe,
   input wire select_t sel,
   input wire logic    reset_seen,
   input wire flags_t  flags
);
   int unsigned oe_cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         oe_cnt_q <= 0;
      else
         oe_cnt_q <= line_oe ? oe_cnt_q + 1 : 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_desel;
      ##[0:2] !sel.valid;
   endsequence
   sequence s_sel;
      ##[0:2] sel.valid;
   endsequence
   AST_DRAIN_ONLY: assert property (line_out == 1'b0)
      else $error("line_out not low");
   AST_OD_COPY: assert property (sel.od == $past(flags.od))
      else $error("sel.od not one cycle behind flag");
   AST_PD_MAX: assert property (oe_cnt_q <= 6002)
      else $error("line held low too long");
   AST_OD_PD_MAX: assert property (flags.od |-> oe_cnt_q <= 802)
      else $error("overdrive drive too long");
   AST_RESET_DESEL: assert property (reset_seen |-> s_desel)
      else $error("selection kept over reset");
   AST_RESUME_SEL: assert property ($rose(flags.resume) |-> s_sel)
      else $error("resume flag without selection");
   AST_OD_SET_QUIET: assert property ($rose(flags.od) |-> !line_oe)
      else $error("overdrive set while driving");
   AST_OD_CLR_LOW: assert property ($fell(flags.od) |-> (!line_in || !$past(line_in) || !$past(line_in, 2)))
      else $error("overdrive cleared without reset");
   AST_OD_PRESENCE: assert property ((reset_seen && flags.od) |-> ##[140:160] line_oe)
      else $error("no overdrive presence after reset");
endmodule // swire_rom_sva

//--- tb/swire_master.sv
/* Behavioural bus master on the single line.
   Assumes it sees the slave enable and makes the sampled line level. */
`timescale 1ns/1ns
module swire_master (
   input  wire logic clk,
   input  wire logic dut_oe,
   output logic      line
);
   logic low_q = 1'b0;
   logic od    = 1'b0;
   assign line = !(low_q || dut_oe);
   task automatic hold(input logic v, input int n);
      low_q <= v;
      repeat (n) @(posedge clk);
   endtask
   task automatic bus_reset(input int n, output logic pd);
      pd = 1'b0;
      hold(1'b1, n);
      low_q <= 1'b0;
      // Stop waiting once the presence pulse has ended, then recover
      repeat (od ? 1200 : 9000) begin
         @(posedge clk);
         if (!line)
            pd = 1'b1;
         else if (pd)
            break;
      end
      repeat (20) @(posedge clk);
   endtask
   // Slot of 160 or 1520 cycles, released high between slots
   task automatic wr_bits(input logic [63:0] v, input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         k = v[i] ? 5 : (od ? 158 : 1510);
         hold(1'b1, k);
         hold(1'b0, (od ? 160 : 1520) - k);
      end
   endtask
   task automatic rd_bits(output logic [63:0] v, input int n);
      v = '1;
      for (int i = 0; i < n; i++) begin
         hold(1'b1, 2);
         hold(1'b0, od ? 20 : 200);
         v[i] = line;
         repeat (od ? 138 : 1318) @(posedge clk);
      end
   endtask
endmodule // swire_master

//--- tb/testbench.sv
/* Self-checking bench for the ROM command layer.
   Assumes one slave on the line, the master model as far side. */
`timescale 1ns/1ns
module testbench;
   import swire_pkg::*;
   localparam logic [63:0] ID = 64'h5A3C_9E17_B2D4_6F09; // Arbitrary value
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        line_in;
   logic        line_out;
   logic        line_oe;
   logic        reset_seen;
   select_t     sel;
   flags_t      flags;
   logic        pd;
   logic [63:0] v;
   int          err_count = 0;
   int          num_checks = 0;
   swire_rom_layer #(.DEVICE_ID(ID)) dut (.clk(clk), .rst(rst), .line_in(line_in), .line_out(line_out),
      .line_oe(line_oe), .sel(sel), .reset_seen(reset_seen), .flags(flags));
   swire_master m (.clk(clk), .dut_oe(line_oe), .line(line_in));
   initial forever #10 clk = ~clk;
   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmd(input logic [7:0] c);
      m.bus_reset(m.od ? 2500 : 12500, pd);
      chk("presence", 1, pd);
      chk("deselect", 0, sel.valid);
      m.wr_bits(c, 8);
   endtask
   task automatic t_od_skip();
      cmd(CMD_OD_SKIP);
      repeat (20) @(posedge clk);
      chk("od set", 1, flags.od);
      chk("skip sel", 1, sel.valid);
      m.od = 1'b1;
   endtask
   task automatic t_read_id();
      cmd(CMD_READ_ID);
      chk("od kept", 1, flags.od);
      m.rd_bits(v, 64);
      chk("identity", ID, v);
   endtask
   task automatic t_od_match();
      cmd(CMD_OD_MATCH);
      m.wr_bits(ID, 64);
      repeat (20) @(posedge clk);
      chk("match sel", 1, sel.valid);
      chk("match od", 1, flags.od);
      chk("resume set", 1, flags.resume);
   endtask
   task automatic t_resume(input logic e);
      cmd(CMD_RESUME);
      repeat (20) @(posedge clk);
      chk("resume sel", e, sel.valid);
   endtask
   task automatic t_search_drop();
      cmd(CMD_SEARCH);
      m.rd_bits(v, 2);
      chk("search pair", {62'h0, ~ID[0], ID[0]}, {62'h0, v[1:0]});
      m.wr_bits(ID, 1);
      m.rd_bits(v, 2);
      chk("search next", {62'h0, ~ID[1], ID[1]}, {62'h0, v[1:0]});
      m.wr_bits(~ID >> 1, 1);
      m.rd_bits(v, 2);
      chk("search silent", 2'h3, v[1:0]);
   endtask
   task automatic t_bad_match();
      cmd(CMD_MATCH);
      m.wr_bits(ID ^ 64'h1, 64);
      repeat (20) @(posedge clk);
      chk("no sel", 0, sel.valid);
      m.rd_bits(v, 8);
      chk("silent", 8'hFF, v[7:0]);
      chk("resume off", 0, flags.resume);
   endtask
   task automatic t_long_reset();
      m.hold(1'b1, 24010);
      m.hold(1'b0, 60);
      chk("od cleared", 0, flags.od);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_od_skip();
      t_read_id();
      t_od_match();
      t_resume(1'b1);
      t_search_drop();
      t_resume(1'b0);
      t_bad_match();
      t_long_reset();
      test_done();
   end
   initial begin
      // About 117k cycles expected; give a quarter more
      #3000000;
      err_count++;
      test_done();
   end
endmodule // testbench
bind swire_rom_layer swire_rom_sva chk_i (.clk(clk), .rst(rst), .line_in(line_in), .line_out(line_out),
   .line_oe(line_oe), .sel(sel), .reset_seen(reset_seen), .flags(flags));
